// *** rtl/jump_and_increment_exec.v ***
// execution of absolute jump, increment file and increment skip zero
`timescale 1ns/1ps
`default_nettype none
`include "jump_inc_consts.vh"
module jump_and_increment_exec (
    input wire core_clk,
    input wire srst,
    input wire instr_valid,
    input wire [11:0] instr_word,
    input wire [7:0] file_rdata,
    output wire [4:0] file_addr,
    output reg [7:0] file_wdata,
    output reg file_we,
    output reg [7:0] acc_q,
    output reg [7:0] status_q,
    output reg [10:0] pc_q,
    output reg flush_q,
    output wire unknown_op
);
    // =================================================================
    // slot states
    // a jump or a taken skip turns the next fetched word into a nop
    localparam [1:0] SLOT_RUN = 2'b00;
    localparam [1:0] SLOT_JUMP = 2'b01;
    localparam [1:0] SLOT_SKIP = 2'b10;

    // =================================================================
    // declarations
    reg [1:0] slot_q;
    reg [1:0] slot_d;
    reg [10:0] pc_d;
    reg [7:0] acc_d;
    reg [7:0] status_d;
    reg flush_d;
    wire issue;
    wire slot_run;
    wire [2:0] jump_field;
    wire [5:0] file_field;
    wire [8:0] jump_target;
    wire [1:0] page_bits;
    wire is_jump;
    wire is_inc;
    wire is_incsk;
    wire dest_file;
    wire inc_to_acc;
    wire inc_to_file;
    wire [8:0] carry;
    wire [7:0] inc_result;
    wire inc_zero;

    // =================================================================
    // issue slot
    assign slot_run = (slot_q == SLOT_RUN);
    assign issue = instr_valid && slot_run;

    // =================================================================
    // jump decode
    assign jump_field = instr_word[`JUMP_OP_HI:`JUMP_OP_LO];
    assign jump_target = instr_word[`JUMP_TGT_HI:0];
    assign page_bits = status_q[`STAT_PAGE_HI:`STAT_PAGE_LO];
    assign is_jump = issue && (jump_field == `JUMP_OPCODE_VAL);

    // =================================================================
    // file register decode
    assign file_field = instr_word[`FILE_OP_HI:`FILE_OP_LO];
    assign is_inc = issue && (file_field == `INC_OPCODE);
    assign is_incsk = issue && (file_field == `INCSKIP_OPCODE);
    assign file_addr = instr_word[`ADDR_HI:0];
    assign dest_file = instr_word[`DEST_BIT];
    // other opcodes belong to the rest of the core
    assign unknown_op = issue && !is_jump && !is_inc && !is_incsk;

    // =================================================================
    // increment carry chain
    assign carry[0] = 1'b1;
    genvar b;
    generate
        for (b = 0; b < 8; b = b + 1) begin : g_inc
            assign inc_result[b] = file_rdata[b] ^ carry[b];
            assign carry[b + 1] = file_rdata[b] & carry[b];
        end
    endgenerate
    // carry out of bit 7 means the value wrapped to zero
    assign inc_zero = carry[8];

    // =================================================================
    // result routing
    assign inc_to_acc = (is_inc || is_incsk) && !dest_file;
    assign inc_to_file = (is_inc || is_incsk) && dest_file;

    // =================================================================
    // file write port
    // combinational so the file takes the result in the decode cycle
    always @* begin
        file_we = 1'b0;
        if (inc_to_file) begin
            file_we = 1'b1;
        end
    end

    // =================================================================
    // file write data
    always @* begin
        file_wdata = inc_result;
    end

    // =================================================================
    // slot state machine
    always @* begin
        slot_d = SLOT_RUN;
        case (slot_q)
            SLOT_RUN: begin
                if (is_jump) begin
                    slot_d = SLOT_JUMP;
                end else if (is_incsk && inc_zero) begin
                    slot_d = SLOT_SKIP;
                end else begin
                    slot_d = SLOT_RUN;
                end
            end
            SLOT_JUMP: begin
                // second cycle of the jump
                slot_d = SLOT_RUN;
            end
            SLOT_SKIP: begin
                // second cycle of a taken skip
                slot_d = SLOT_RUN;
            end
            default: begin
                slot_d = SLOT_RUN;
            end
        endcase
    end

    // =================================================================
    // flush flag
    always @* begin
        flush_d = (slot_d != SLOT_RUN);
    end

    // =================================================================
    // program counter
    // the pc moves on every valid word, dropped ones included
    always @* begin
        pc_d = pc_q;
        if (instr_valid) begin
            pc_d = pc_q + 11'h001;
        end
        if (is_jump) begin
            pc_d = {page_bits, jump_target};
        end
    end

    // =================================================================
    // accumulator
    always @* begin
        acc_d = acc_q;
        if (inc_to_acc) begin
            acc_d = inc_result;
        end
    end

    // =================================================================
    // status register
    // only the plain increment touches a flag
    always @* begin
        status_d = status_q;
        if (is_inc) begin
            status_d[`STAT_ZERO_BIT] = inc_zero;
        end
    end

    // =================================================================
    // slot register
    always @(posedge core_clk) begin
        if (srst) begin
            slot_q <= SLOT_RUN;
        end else begin
            slot_q <= slot_d;
        end
    end

    // =================================================================
    // flush register
    always @(posedge core_clk) begin
        if (srst) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= flush_d;
        end
    end

    // =================================================================
    // program counter register
    always @(posedge core_clk) begin
        if (srst) begin
            pc_q <= `PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    // =================================================================
    // accumulator register
    always @(posedge core_clk) begin
        if (srst) begin
            acc_q <= 8'h00;
        end else begin
            acc_q <= acc_d;
        end
    end

    // =================================================================
    // status register flops
    always @(posedge core_clk) begin
        if (srst) begin
            status_q <= `STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

endmodule // jump_and_increment_exec
`default_nettype wire

// *** rtl/jump_inc_consts.vh ***
// constants for the jump and increment execution block
// =====================================================================
// Function
// - jump opcode 101 loads its 9-bit target into pc bits 8..0.
// - jump fills pc bits 10..9 from status bits 6..5.
// - jump takes two cycles and changes no status flag.
// - increment file adds one; d=0 writes accumulator, d=1 writes file.
// - increment file takes one cycle and sets zero flag from result.
// - increment skip routes result by d and leaves status unchanged.
// - increment skip result zero discards fetched instruction, runs a nop.
// - increment skip takes one cycle, or two when skipping.
`ifndef JUMP_INC_CONSTS_VH
`define JUMP_INC_CONSTS_VH
`define JUMP_OP_HI 11
`define JUMP_OP_LO 9
`define JUMP_TGT_HI 8
`define JUMP_OPCODE 3'h7
`define JUMP_OPCODE_VAL 3'h5
`define FILE_OP_HI 11
`define FILE_OP_LO 6
`define INC_OPCODE 6'h0a
`define INCSKIP_OPCODE 6'h0f
`define DEST_BIT 5
`define ADDR_HI 4
`define STAT_PAGE_HI 6
`define STAT_PAGE_LO 5
`define STAT_ZERO_BIT 2
`define PC_RESET 11'h7ff
`define STATUS_RESET 8'h18
`endif

// *** tb/jump_and_increment_exec_checker.sv ***
// checker for jump and increment execution
`timescale 1ns/1ps
`default_nettype none
module jie_checker (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic instr_valid,
    input wire logic [11:0] instr_word,
    input wire logic [7:0] file_rdata,
    input wire logic [4:0] file_addr,
    input wire logic [7:0] file_wdata,
    input wire logic file_we,
    input wire logic [7:0] acc_q,
    input wire logic [7:0] status_q,
    input wire logic [10:0] pc_q,
    input wire logic flush_q,
    input wire logic unknown_op
);
default clocking @(posedge core_clk); endclocking
default disable iff (srst);
wire t = instr_valid & !flush_q;
sequence s_jump_issue;
    t && instr_word[11:9] == 3'h5;
endsequence
sequence s_inc_issue;
    t && instr_word[11:6] == 6'h0a;
endsequence
sequence s_skip_issue;
    t && instr_word[11:6] == 6'h0f;
endsequence
sequence s_dropped_slot;
    flush_q ##1 !flush_q;
endsequence
a_jump_load: assert property (s_jump_issue |=> flush_q && $stable(status_q) &&
    pc_q == {$past(status_q[6:5]), $past(instr_word[8:0])}) else $error("jump load");
a_jump_two: assert property (s_jump_issue |=> s_dropped_slot) else $error("jump length");
a_inc_route: assert property (s_inc_issue |=> acc_q ==
    ($past(instr_word[5]) ? $past(acc_q) : $past(file_rdata) + 8'h01)) else $error("inc route");
a_zero_flag: assert property (s_inc_issue |=>
    status_q[2] == ($past(file_rdata) == 8'hff)) else $error("zero flag");
a_skip_zero: assert property (s_skip_issue |=> $stable(status_q) &&
    flush_q == ($past(file_rdata) == 8'hff)) else $error("skip");
a_skip_route: assert property (s_skip_issue |=> acc_q ==
    ($past(instr_word[5]) ? $past(acc_q) : $past(file_rdata) + 8'h01)) else $error("skip route");
a_slot_ignored: assert property (flush_q |-> !file_we ##1 $stable(acc_q) && $stable(status_q))
    else $error("dropped word acted");
a_file_index: assert property (file_addr == instr_word[4:0]) else $error("file address");
a_file_write: assert property (file_we |-> instr_word[5] && file_wdata == file_rdata + 8'h01)
    else $error("file write");
a_flush_once: assert property (flush_q |=> !flush_q) else $error("flush length");
endmodule // jie_checker
bind jump_and_increment_exec jie_checker jie_checker_i(.*);
`default_nettype wire

// *** tb/test_jump_and_increment_exec.sv ***
// bench for jump and increment execution
`timescale 1ns/1ps
`default_nettype none
module test_jump_and_increment_exec;
logic core_clk = 0, srst = 1, instr_valid = 0, flush_q, file_we, unknown_op;
logic [11:0] instr_word = 0;
logic [7:0] file_rdata = 0, file_wdata, acc_q, status_q;
logic [10:0] pc_q;
logic [4:0] file_addr;
int n_fail = 0, n_checks = 0;
// instruction, file data, expected write enable, write data, address, unknown flag,
// then expected accumulator and flush after the edge
logic [43:0] rows [6] = '{
    {12'h28b, 8'h41, 1'b0, 8'h42, 5'h0b, 1'b0, 8'h42, 1'b0},
    {12'h3c3, 8'hff, 1'b0, 8'h00, 5'h03, 1'b0, 8'h00, 1'b1},
    {12'h2a3, 8'h10, 1'b0, 8'h11, 5'h03, 1'b0, 8'h00, 1'b0},
    {12'hb23, 8'h00, 1'b0, 8'h01, 5'h03, 1'b0, 8'h00, 1'b1},
    {12'h28b, 8'h41, 1'b0, 8'h42, 5'h0b, 1'b0, 8'h00, 1'b0},
    {12'h2ab, 8'hff, 1'b1, 8'h00, 5'h0b, 1'b0, 8'h00, 1'b0}};
jump_and_increment_exec jump_and_increment_exec_i(.*);
initial forever #10 core_clk = ~core_clk;
task chk(logic [26:0] s, e);
    n_checks++;
    if (s !== e) begin
        n_fail++;
        $display("mismatch %0t seen %h expected %h", $time, s, e);
    end
endtask
task conclude;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
initial begin
    repeat (8) @(posedge core_clk);
    srst <= 0;
    #1 chk({pc_q, acc_q, status_q}, {11'h7ff, 8'h00, 8'h18});
    foreach (rows[i]) begin
        @(posedge core_clk);
        instr_valid <= 1;
        {instr_word, file_rdata} <= rows[i][43:24];
        #1 chk({file_we, file_wdata, file_addr, unknown_op}, rows[i][23:9]);
        if (i > 0) chk({acc_q, flush_q}, rows[i-1][8:0]);
    end
    @(posedge core_clk);
    instr_word <= 12'h000;
    #1 chk({acc_q, flush_q}, rows[5][8:0]);
    chk({pc_q, status_q}, {11'h125, 8'h1c});
    chk(unknown_op, 1'b1);
    @(posedge core_clk);
    instr_word <= 12'ha05;
    #1 chk({pc_q, acc_q, status_q}, {11'h126, 8'h00, 8'h1c});
    @(posedge core_clk);
    instr_word <= 12'h3e0;
    #1 chk({file_we, flush_q, pc_q}, {1'b0, 1'b1, 11'h005});
    @(posedge core_clk);
    instr_valid <= 0;
    #1 chk({flush_q, pc_q, status_q}, {1'b0, 11'h006, 8'h1c});
    @(posedge core_clk);
    srst <= 1;
    repeat (2) @(posedge core_clk);
    srst <= 0;
    #1 chk({pc_q, acc_q, status_q, flush_q}, {11'h7ff, 8'h00, 8'h18, 1'b0});
    @(posedge core_clk);
    instr_valid <= 1;
    instr_word <= 12'h28b;
    file_rdata <= 8'h41;
    @(posedge core_clk);
    instr_valid <= 0;
    #1 chk({pc_q, acc_q}, {11'h000, 8'h42});
    conclude;
end
endmodule // test_jump_and_increment_exec
`default_nettype wire
